// file: wdp_pkg.sv
package wdp_pkg;
   // register map
   localparam logic [3:0] OPT_ADDR      = 4'h0;
   localparam logic [3:0] STAT_ADDR     = 4'h1;
   localparam logic [3:0] CLEAR_ADDR    = 4'h2;
   localparam logic [7:0] OPT_RESET     = 8'h00;
   localparam int         SEL_LO_BIT    = 0;
   localparam int         SEL_HI_BIT    = 1;
   localparam int         ZERO_BIT      = 2;
   localparam logic [7:0] OPT_WR_MASK   = 8'hFB;
   // clearing sequence key bytes
   localparam logic [7:0] CLR_KEY_ARM   = 8'h55;
   localparam logic [7:0] CLR_KEY_FIRE  = 8'hAA;
   // divider chain
   localparam int         TAP_BITS      = 15;
   localparam int         POST_BITS     = 6;
   localparam int         POST_DIV_1    = 0;
   localparam int         POST_DIV_4    = 2;
   localparam int         POST_DIV_16   = 4;
   localparam int         POST_DIV_64   = 6;
   // write-once window after reset
   localparam int         WIN_CYCLES    = 64;
   localparam int         WIN_BITS      = 7;
endpackage

// file: wdp_post_div.sv
`timescale 1ns/1ps
`default_nettype none
module wdp_post_div #(
   parameter int BITS = wdp_pkg::POST_BITS
) (
   input  wire logic       i_clk,    // bus clock
   input  wire logic       i_rst_n,  // sync reset, active low
   input  wire logic       i_ce,     // clock enable
   input  wire logic       i_clr,    // clearing sequence done
   input  wire logic       i_tap,    // tap pulse
   input  wire logic [1:0] i_sel,    // rate select
   output logic            o_expire  // one-cycle time-out pulse
);
   logic [BITS-1:0] cnt;
   logic [BITS-1:0] mask;
   wire             wrap;
   assign mask = (i_sel == 2'b00) ? BITS'(0)
               : (i_sel == 2'b01) ? BITS'(2**wdp_pkg::POST_DIV_4 - 1)
               : (i_sel == 2'b10) ? BITS'(2**wdp_pkg::POST_DIV_16 - 1)
               : BITS'(2**wdp_pkg::POST_DIV_64 - 1);
   assign wrap = i_tap & ((cnt & mask) == mask);
   always_ff @(posedge i_clk) begin
      if (!i_rst_n) begin
         cnt      <= '0;
         o_expire <= 1'b0;
      end else if (i_ce) begin
         o_expire <= 1'b0;
         if (i_clr) begin
            cnt <= '0;
         end else if (i_tap) begin
            cnt      <= wrap ? '0 : cnt + 1'b1;
            o_expire <= wrap;
         end
      end
   end
endmodule
`default_nettype wire

// file: wdp_tap_div.sv
`timescale 1ns/1ps
`default_nettype none
// free-running prefix, no reset input by design
module wdp_tap_div #(
   parameter int BITS = wdp_pkg::TAP_BITS
) (
   input  wire logic i_clk,   // bus clock
   input  wire logic i_ce,    // clock enable
   output logic      o_tap    // one-cycle pulse every 2^BITS cycles
);
   logic [BITS-1:0] cnt = '0;
   always_ff @(posedge i_clk) begin
      if (i_ce) begin
         cnt <= cnt + 1'b1;
      end
   end
   assign o_tap = i_ce & (&cnt);
endmodule
`default_nettype wire

// file: wdp_top.sv
// Operation
// [R1] watchdog clocked by bus clock divided by 2^15 from main chain
// [R2] prefix stages unreset; post stages cleared by clearing sequence
// [R3] first tap after clear lands anywhere in one tap period
// [R4] rate bits select post division 1, 4, 16 or 64
// [R5] reset clears both rate bits, shortest time-out
// [R6] one rate write only, within 64 cycles after reset, normal modes
// [R7] config bit 2 reads zero; whole register resets to zero
// [R8] completed count without clearing raises time-out toward reset logic
`timescale 1ns/1ps
`default_nettype none
module wdp_top (
   input  wire logic       i_clk,        // 125 MHz bus clock
   input  wire logic       i_rst_n,      // sync reset, active low
   input  wire logic       i_ce,         // clock enable
   input  wire logic       i_special,    // special mode, lifts write-once
   input  wire logic [3:0] i_addr,       // register address
   input  wire logic [7:0] i_wdata,      // write data
   input  wire logic       i_wr,         // write strobe
   input  wire logic       i_rd,         // read strobe
   output logic      [7:0] o_rdata,      // read data, cycle after strobe
   output logic            o_timeout,    // time-out pulse to reset logic
   output logic            o_analog_power_up,         // config bit 7
   output logic            o_converter_clock_select,  // config bit 6
   output logic            o_irq_edge_select,         // config bit 5
   output logic            o_oscillator_startup_delay,// config bit 4
   output logic            o_clock_monitor_enable     // config bit 3
);
   ////////////////////////////////////////////////////////////////////////
   logic [7:0]                    system_config_options;
   logic [wdp_pkg::WIN_BITS-1:0]  win_cnt;
   logic                          rate_written;
   logic                          armed;
   logic                          clr_pulse;
   logic                          special_meta;
   logic                          special_sync;
   logic [7:0]                    next_rdata;
   wire                           tap;
   wire                           in_window;
   wire                           wr_opt;
   wire                           rate_ok;
   wire                           wr_clr;
   wire [1:0]                     rate_sel;

   assign in_window = win_cnt < wdp_pkg::WIN_BITS'(wdp_pkg::WIN_CYCLES);
   assign wr_opt    = i_wr & (i_addr == wdp_pkg::OPT_ADDR);
   assign rate_ok   = special_sync | (in_window & ~rate_written); // R6
   assign wr_clr    = i_wr & (i_addr == wdp_pkg::CLEAR_ADDR);
   assign rate_sel  = {system_config_options[wdp_pkg::SEL_HI_BIT],
                       system_config_options[wdp_pkg::SEL_LO_BIT]};

   ////////////////////////////////////////////////////////////////////////
   // mode pin passes two flops before use
   always_ff @(posedge i_clk) begin
      if (!i_rst_n) begin
         special_meta <= 1'b0;
         special_sync <= 1'b0;
      end else if (i_ce) begin
         special_meta <= i_special;
         special_sync <= special_meta;
      end
   end

   // write-once window counter
   always_ff @(posedge i_clk) begin
      if (!i_rst_n) begin
         win_cnt      <= '0;
         rate_written <= 1'b0;
      end else if (i_ce) begin
         if (in_window) begin
            win_cnt <= win_cnt + 1'b1; // R6
         end
         if (wr_opt) begin
            rate_written <= 1'b1; // R6
         end
      end
   end

   // config register
   always_ff @(posedge i_clk) begin
      if (!i_rst_n) begin
         system_config_options <= wdp_pkg::OPT_RESET; // R5 R7
      end else if (i_ce && wr_opt) begin
         system_config_options[7:3] <= i_wdata[7:3];
         system_config_options[wdp_pkg::ZERO_BIT] <= 1'b0; // R7
         if (rate_ok) begin
            system_config_options[1:0] <= i_wdata[1:0]; // R6
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // clearing sequence: arm key then fire key
   always_ff @(posedge i_clk) begin
      if (!i_rst_n) begin
         armed     <= 1'b0;
         clr_pulse <= 1'b0;
      end else if (i_ce) begin
         clr_pulse <= 1'b0;
         if (wr_clr) begin
            if (i_wdata == wdp_pkg::CLR_KEY_ARM) begin
               armed <= 1'b1;
            end else if (armed && i_wdata == wdp_pkg::CLR_KEY_FIRE) begin
               armed     <= 1'b0;
               clr_pulse <= 1'b1; // R2
            end
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // read port
   always_comb begin
      next_rdata = 8'h00;
      case (i_addr)
         wdp_pkg::OPT_ADDR: begin
            next_rdata = system_config_options & wdp_pkg::OPT_WR_MASK; // R7
         end
         wdp_pkg::STAT_ADDR: begin
            next_rdata = {5'b0_0000, armed, rate_written, in_window};
         end
         default: begin
            next_rdata = 8'h00;
         end
      endcase
   end

   always_ff @(posedge i_clk) begin
      if (!i_rst_n) begin
         o_rdata <= 8'h00;
      end else if (i_ce) begin
         o_rdata <= i_rd ? next_rdata : 8'h00;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   wdp_tap_div #(.BITS(wdp_pkg::TAP_BITS)) u_tap ( // R1 R2 R3
      .i_clk (i_clk),
      .i_ce  (i_ce),
      .o_tap (tap)
   );

   wdp_post_div #(.BITS(wdp_pkg::POST_BITS)) u_post ( // R4 R8
      .i_clk    (i_clk),
      .i_rst_n  (i_rst_n),
      .i_ce     (i_ce),
      .i_clr    (clr_pulse),
      .i_tap    (tap),
      .i_sel    (rate_sel),
      .o_expire (o_timeout)
   );

   assign o_analog_power_up          = system_config_options[7];
   assign o_converter_clock_select   = system_config_options[6];
   assign o_irq_edge_select          = system_config_options[5];
   assign o_oscillator_startup_delay = system_config_options[4];
   assign o_clock_monitor_enable     = system_config_options[3];
endmodule
`default_nettype wire

// file: wdp_top_bench.sv
`timescale 1ns/1ps
`default_nettype none
module wdp_top_bench;
   logic       i_clk = 1'b0, i_rst_n = 1'b0, i_wr = 1'b0, i_rd = 1'b0;
   logic       o_timeout;
   logic [3:0] i_addr = 4'h0;
   logic [7:0] i_wdata = 8'h00, o_rdata;
   logic [4:0] cfg;
   int         error_cnt = 0, comparisons = 0;
   always #4 i_clk = ~i_clk;
   wdp_top dut_u (.i_clk, .i_rst_n, .i_ce(1'b1), .i_special(1'b0), .i_addr,
      .i_wdata, .i_wr, .i_rd, .o_rdata, .o_timeout,
      .o_analog_power_up(cfg[4]), .o_converter_clock_select(cfg[3]),
      .o_irq_edge_select(cfg[2]), .o_oscillator_startup_delay(cfg[1]),
      .o_clock_monitor_enable(cfg[0]));
   task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
      comparisons++;
      if (got !== exp) error_cnt++;
      if (got !== exp) $display("BAD %0t got %0h exp %0h", $time, got, exp);
   endtask
   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      {i_wr, i_addr, i_wdata} <= {1'b1, a, d};
      @(posedge i_clk) i_wr <= 1'b0;
      @(posedge i_clk);
   endtask
   task automatic rd(input logic [3:0] a, input logic [7:0] exp);
      {i_rd, i_addr} <= {1'b1, a};
      @(posedge i_clk) i_rd <= 1'b0;
      @(negedge i_clk) cmp(o_rdata, exp);
      @(posedge i_clk);
   endtask
   task automatic t_rate;
      repeat (10) @(posedge i_clk);
      i_rst_n <= 1'b1;
      @(posedge i_clk);
      rd(4'h0, 8'h00);
      wr(4'h0, 8'hFF);
      rd(4'h0, 8'hFB);
      cmp(cfg, 5'h1F);
      wr(4'h0, 8'h00);
      rd(4'h0, 8'h03);
      i_rst_n <= 1'b0;
      repeat (10) @(posedge i_clk);
      i_rst_n <= 1'b1;
      repeat (70) @(posedge i_clk);
      rd(4'h1, 8'h00);
      wr(4'h0, 8'h03);
      rd(4'h0, 8'h00);
      rd(4'hF, 8'h00);
      $display("rate select test done");
   endtask
   task automatic t_expire;
      int n;
      for (n = 0; n < 33000 && o_timeout !== 1'b1; n++) @(negedge i_clk);
      cmp(n < 33000, 1);
      @(posedge i_clk);
      wr(4'h2, 8'h55);
      wr(4'h2, 8'hAA);
      for (n = 4; n < 33000 && o_timeout !== 1'b1; n++) @(negedge i_clk);
      cmp(n, 2 ** wdp_pkg::TAP_BITS);
      $display("expiry test done");
   endtask
   task automatic summarize;
      $display("comparisons %0d error_cnt %0d", comparisons, error_cnt);
      if (error_cnt == 0 && comparisons > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask
   initial begin t_rate; t_expire; summarize; end
   initial begin #(8 * 80000) error_cnt++; summarize; end
endmodule
`default_nettype wire

// file: wdp_top_properties.sv
`timescale 1ns/1ps
`default_nettype none
module wdp_chk (
   input wire logic       i_clk,    // clk
   input wire logic       i_rst_n,  // rst
   input wire logic [3:0] i_addr,   // addr
   input wire logic [7:0] i_wdata,  // wdata
   input wire logic       i_wr,     // wr
   input wire logic       i_rd,     // rd
   input wire logic [7:0] o_rdata,  // rdata
   input wire logic       o_timeout // expiry
);
   logic [6:0] cnt;
   logic [1:0] sel;
   logic       used;
   wire        wr0 = i_wr && i_addr == wdp_pkg::OPT_ADDR;
   always_ff @(posedge i_clk) begin
      cnt  <= !i_rst_n ? 7'd0 : cnt + {6'd0, cnt < 7'd64};
      used <= i_rst_n && (used || wr0);
      sel  <= !i_rst_n ? 2'b00 :
              (wr0 && !used && cnt < 7'd64) ? i_wdata[1:0] : sel;
   end
   default clocking @(posedge i_clk); endclocking
   default disable iff (!i_rst_n);
   sequence rd_opt; i_rd && i_addr == wdp_pkg::OPT_ADDR; endsequence
   a_bit2_zero: assert property (o_rdata[2] == 1'b0)
      else $error("bit 2 set");
   a_rdata_idle: assert property (!$past(i_rd) |-> o_rdata == 8'h00)
      else $error("stray read data");
   a_rate_once: assert property (rd_opt |=> o_rdata[1:0] == sel)
      else $error("rate bits wrong");
   a_cfg_kept: assert property (wr0 ##1 rd_opt |=>
      o_rdata[7:3] == $past(i_wdata[7:3], 2)) else $error("config lost");
   a_unmapped_zero: assert property (i_rd && i_addr > 4'h2 |=>
      o_rdata == 8'h00) else $error("unmapped read");
   a_window_flag: assert property (i_rd && i_addr == 4'h1 |=>
      o_rdata[0] == ($past(cnt) < 7'd64)) else $error("window flag");
   a_timeout_gap: assert property (o_timeout |=> !o_timeout [*8])
      else $error("expiry too close");
   a_reset_zero: assert property ($rose(i_rst_n) |->
      o_rdata == 8'h00 && !o_timeout) else $error("reset state");
endmodule
bind wdp_top wdp_chk chk_u (.*);
`default_nettype wire
